// *** hw/pidpc_regs.v ***
// Paged identification and vendor registers with strapped power class, Wishbone slave.
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "pidpc_map.vh"

module pidpc_regs #(
  parameter [23:0] ORG_ID  = 24'h123456,
  parameter [23:0] PART_ID = 24'habcdef
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        arst_n,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Strap pins
  input  wire [2:0]  power_class_strap_pins,
  // Power class towards self-ID and the rest of the section
  output reg  [2:0]  selfIdPower,
  output reg         powerSelfSupplied,
  output reg         powerBusDrawn,
  output reg         powerClassReserved,
  // Hard reset pulse to the rest of the section
  output reg         phyHardReset
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // True when a paged index is reached while the given page is selected.
  function pageHit;
    input [3:0] idx;
    input [2:0] sel;
    input [2:0] page;
    begin
      pageHit = (idx >= `PIDPC_IDX_PAGED_BASE) && (sel == page);
    end
  endfunction

  // Class kind as {reserved, bus powered, self powered}.
  function [2:0] powerKind;
    input [2:0] code;
    begin
      case (code)
        `PIDPC_PWR_SELF_15W,
        `PIDPC_PWR_SELF_30W,
        `PIDPC_PWR_SELF_5W:     powerKind = 3'h1;
        `PIDPC_PWR_BUS_3W,
        `PIDPC_PWR_BUS_PLUS_3W,
        `PIDPC_PWR_BUS_PLUS_7W: powerKind = 3'h2;
        `PIDPC_PWR_RESERVED:    powerKind = 3'h4;
        default:                powerKind = 3'h0;
      endcase
    end
  endfunction

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire [3:0] index;
  wire       request;
  wire       writeLow;
  reg        stage;
  reg        strapLoaded;
  reg [2:0]  pageSel;
  reg [2:0]  pwrClass;
  wire [7:0] romData;
  wire       commit;
  wire       idPage;
  wire       vendorPage;
  reg [7:0]  next_readByte;
  wire [2:0] kind;

  assign index      = wb_adr_i[5:2];
  assign request    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign commit     = request & stage;
  assign writeLow   = commit & wb_we_i & wb_sel_i[0];
  assign idPage     = pageHit(index, pageSel, `PIDPC_PAGE_ID);
  assign vendorPage = pageHit(index, pageSel, `PIDPC_PAGE_VENDOR);
  assign kind       = powerKind(pwrClass);

  pidpc_id_rom #(
    .ORG_ID  (ORG_ID),
    .PART_ID (PART_ID)
  ) u_id_rom (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .index   (index),
    .data    (romData)
  );

  // ****************************************************************
  // Read data select
  // ****************************************************************
  always @* begin
    next_readByte = 8'h00;
    if (index == `PIDPC_IDX_POWER_CLASS) begin
      next_readByte[`PIDPC_PWR_MSB:`PIDPC_PWR_LSB] = pwrClass;
    end else if (index == `PIDPC_IDX_PAGE_SELECT) begin
      next_readByte[`PIDPC_PAGE_MSB:`PIDPC_PAGE_LSB] = pageSel;
    end else if (idPage) begin
      if (index == `PIDPC_IDX_COMPLIANCE) begin
        next_readByte = `PIDPC_COMPLIANCE_VAL;
      end else begin
        next_readByte = romData;
      end
    end
    // The vendor page, including the reset bit, always reads zero.
    if (vendorPage) begin
      next_readByte = 8'h00;
    end
  end

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // Two cycles per access give the identifier store time to register its byte.
  // The handshake flops survive the software reset so the write that fires it is still acked.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage    <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      stage    <= request & ~stage;
      wb_ack_o <= commit;
      if (commit && !wb_we_i) begin
        wb_dat_o <= {24'h000000, next_readByte};
      end
    end
  end

  // ****************************************************************
  // Software hard reset
  // ****************************************************************
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phyHardReset <= 1'b0;
    end else begin
      phyHardReset <= writeLow && vendorPage && (index == `PIDPC_IDX_RESET_CTRL)
                      && wb_dat_i[`PIDPC_SWRESET_BIT];
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // The software reset clears pageSel, pwrClass and strapLoaded as the pin does, one cycle after the write.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pageSel     <= `PIDPC_PAGE_RESET;
      pwrClass    <= `PIDPC_PWR_RESET;
      strapLoaded <= 1'b0;
    end else if (phyHardReset) begin
      pageSel     <= `PIDPC_PAGE_RESET;
      pwrClass    <= `PIDPC_PWR_RESET;
      strapLoaded <= 1'b0;
    end else if (!strapLoaded) begin
      // Straps are caught on the first edge after any hard reset.
      pwrClass    <= power_class_strap_pins;
      strapLoaded <= 1'b1;
    end else if (writeLow) begin
      if (index == `PIDPC_IDX_PAGE_SELECT) begin
        pageSel <= wb_dat_i[`PIDPC_PAGE_MSB:`PIDPC_PAGE_LSB];
      end
      if (index == `PIDPC_IDX_POWER_CLASS) begin
        pwrClass <= wb_dat_i[`PIDPC_PWR_MSB:`PIDPC_PWR_LSB];
      end
    end
  end

  // ****************************************************************
  // Power class outputs
  // ****************************************************************
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      selfIdPower        <= `PIDPC_PWR_RESET;
      powerSelfSupplied  <= 1'b0;
      powerBusDrawn      <= 1'b0;
      powerClassReserved <= 1'b0;
    end else begin
      selfIdPower        <= pwrClass;
      powerSelfSupplied  <= kind[0];
      powerBusDrawn      <= kind[1];
      powerClassReserved <= kind[2];
    end
  end

endmodule // pidpc_regs

`default_nettype wire

// *** hw/pidpc_map.vh ***
// Register map, field positions, reset values and timing counts of the PHY id page block.
`ifndef PIDPC_MAP_VH
`define PIDPC_MAP_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define PIDPC_IDX_POWER_CLASS   4'h4
`define PIDPC_IDX_PAGE_SELECT   4'h7
`define PIDPC_IDX_COMPLIANCE    4'h8
`define PIDPC_IDX_ID_RESERVED   4'h9
`define PIDPC_IDX_ORG_ID0       4'ha
`define PIDPC_IDX_ORG_ID1       4'hb
`define PIDPC_IDX_ORG_ID2       4'hc
`define PIDPC_IDX_PART_ID0      4'hd
`define PIDPC_IDX_PART_ID1      4'he
`define PIDPC_IDX_RESET_CTRL    4'he
`define PIDPC_IDX_PART_ID2      4'hf
`define PIDPC_IDX_PAGED_BASE    4'h8

// ****************************************************************
// Pages
// ****************************************************************
`define PIDPC_PAGE_ID           3'h1
`define PIDPC_PAGE_VENDOR       3'h7

// ****************************************************************
// Field positions
// ****************************************************************
`define PIDPC_PWR_LSB           0
`define PIDPC_PWR_MSB           2
`define PIDPC_PAGE_LSB          5
`define PIDPC_PAGE_MSB          7
`define PIDPC_SWRESET_BIT       7

// ****************************************************************
// Reset and fixed values
// ****************************************************************
`define PIDPC_COMPLIANCE_VAL    8'h02
`define PIDPC_PAGE_RESET        3'h0
`define PIDPC_PWR_RESET         3'h0

// ****************************************************************
// Power class codes
// ****************************************************************
`define PIDPC_PWR_NONE          3'h0
`define PIDPC_PWR_SELF_15W      3'h1
`define PIDPC_PWR_SELF_30W      3'h2
`define PIDPC_PWR_SELF_5W       3'h3
`define PIDPC_PWR_BUS_3W        3'h4
`define PIDPC_PWR_RESERVED      3'h5
`define PIDPC_PWR_BUS_PLUS_3W   3'h6
`define PIDPC_PWR_BUS_PLUS_7W   3'h7

// ****************************************************************
// Timing
// ****************************************************************
`define PIDPC_CLK_PERIOD_NS     50
`define PIDPC_RESET_MIN_NS      2000000
`define PIDPC_RESET_MIN_CYCLES  ((`PIDPC_RESET_MIN_NS + `PIDPC_CLK_PERIOD_NS - 1) / `PIDPC_CLK_PERIOD_NS)

`endif

// *** hw/pidpc_id_rom.v ***
// Identification byte store with registered read data.
`timescale 1ns/1ps
`default_nettype none
`include "pidpc_map.vh"

module pidpc_id_rom #(
  parameter [23:0] ORG_ID  = 24'h123456,
  parameter [23:0] PART_ID = 24'habcdef
) (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       arst_n,
  // Read port
  input  wire [3:0] index,
  output reg  [7:0] data
);

  // ****************************************************************
  // Byte select, most significant byte at the lowest index
  // ****************************************************************
  reg [7:0] next_data;

  always @* begin
    case (index)
      `PIDPC_IDX_ORG_ID0:  next_data = ORG_ID[23:16];
      `PIDPC_IDX_ORG_ID1:  next_data = ORG_ID[15:8];
      `PIDPC_IDX_ORG_ID2:  next_data = ORG_ID[7:0];
      `PIDPC_IDX_PART_ID0: next_data = PART_ID[23:16];
      `PIDPC_IDX_PART_ID1: next_data = PART_ID[15:8];
      `PIDPC_IDX_PART_ID2: next_data = PART_ID[7:0];
      default:             next_data = 8'h00;
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data <= 8'h00;
    end else begin
      data <= next_data;
    end
  end

endmodule // pidpc_id_rom

`default_nettype wire

// *** test/pidpc_regs_asserts.sv ***
// Concurrent checks of the PHY id page register block.
`timescale 1ns/1ps
`default_nettype none
module pidpc_regs_asserts #(
  parameter [23:0] ORG_ID  = 24'h123456,
  parameter [23:0] PART_ID = 24'habcdef
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        arst_n,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Power class
  input wire logic [2:0]  power_class_strap_pins,
  input wire logic [2:0]  selfIdPower,
  input wire logic        powerSelfSupplied,
  input wire logic        powerBusDrawn,
  input wire logic        powerClassReserved,
  input wire logic        phyHardReset
);
  logic [2:0] pg;
  wire  [3:0] idx = wb_adr_i[5:2];
  wire        rdAck = wb_ack_o && !wb_we_i;
  wire        wrAck = wb_ack_o && wb_we_i && wb_sel_i[0];
  // The page is shadowed here, so paged answers are judged without looking inside.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) pg <= 3'h0;
    else if (phyHardReset) pg <= 3'h0;
    else if (wrAck && idx == 4'h7) pg <= wb_dat_i[7:5];
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence sAckOnce; wb_ack_o ##1 !wb_ack_o; endsequence
  sequence sPulse; phyHardReset ##1 !phyHardReset; endsequence
  chk_ack_latency: assert property ($rose(wb_cyc_i && wb_stb_i) |-> ##1 !wb_ack_o ##1 sAckOnce)
    else $error("ack timing wrong");
  chk_id_compliance: assert property (rdAck && pg == 3'h1 && idx == 4'h8 |-> wb_dat_o == 32'h02)
    else $error("compliance level wrong");
  chk_id_org_msb: assert property (rdAck && pg == 3'h1 && idx == 4'ha |-> wb_dat_o[7:0] == ORG_ID[23:16])
    else $error("organization byte wrong");
  chk_page_readback: assert property (rdAck && idx == 4'h7 |-> wb_dat_o[7:5] == pg)
    else $error("page select wrong");
  chk_vendor_zero: assert property (rdAck && pg == 3'h7 && idx > 4'h7 |-> wb_dat_o == 32'h0)
    else $error("vendor page not zero");
  chk_unmapped_zero: assert property (rdAck && (idx < 4'h4 || idx == 4'h5
      || idx == 4'h6 || (idx > 4'h7 && pg != 3'h1 && pg != 3'h7)) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_swr_pulse: assert property (wrAck && pg == 3'h7 && idx == 4'he && wb_dat_i[7] |-> sPulse)
    else $error("no hard reset pulse");
  chk_strap_reload: assert property (phyHardReset |-> ##[3:4] selfIdPower == power_class_strap_pins)
    else $error("strap not reloaded");
  chk_pwr_write: assert property (wrAck && idx == 4'h4 |=> selfIdPower == $past(wb_dat_i[2:0]))
    else $error("power class write lost");
  chk_pwr_decode: assert property ({powerSelfSupplied, powerBusDrawn, powerClassReserved} ==
      {selfIdPower inside {3'h1, 3'h2, 3'h3}, selfIdPower inside {3'h4, 3'h6, 3'h7}, selfIdPower == 3'h5})
    else $error("power class decode wrong");
endmodule // pidpc_regs_asserts
bind pidpc_regs pidpc_regs_asserts #(.ORG_ID(ORG_ID), .PART_ID(PART_ID)) u_chk (.*);
`default_nettype wire

// *** test/pidpc_link_model.sv ***
// Link-layer register master model speaking classic Wishbone.
`timescale 1ns/1ps
`default_nettype none
module pidpc_link_model (
  // Clock
  input  wire logic        ref_clk,
  // Wishbone master
  output var  logic        wb_cyc_o,
  output var  logic        wb_stb_o,
  output var  logic        wb_we_o,
  output var  logic [5:0]  wb_adr_o,
  output var  logic [3:0]  wb_sel_o,
  output var  logic [31:0] wb_dat_o,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_i
);
  initial {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
  // The wait has no bound of its own; the bench watchdog ends a hang.
  task automatic xfer(input logic we, input logic [3:0] sel, input logic [3:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd);
    @(posedge ref_clk);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= {idx, 2'h0};
    wb_sel_o <= sel;
    wb_dat_o <= {24'h0, wd};
    do @(posedge ref_clk); while (wb_ack_i !== 1'b1);
    rd = wb_dat_i[7:0];
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    // Released address and data lines change, so a stale value is never taken for a valid one.
    wb_adr_o <= ~wb_adr_o;
    wb_dat_o <= ~wb_dat_o;
  endtask
endmodule // pidpc_link_model
`default_nettype wire

// *** test/pidpc_regs_tb.sv ***
// Self-checking bench of the PHY id page register block.
`timescale 1ns/1ps
`default_nettype none
module pidpc_regs_tb;
  // Identifier values are arbitrary.
  localparam logic [23:0] ORG    = 24'h5a3c81;
  localparam logic [23:0] PART   = 24'h1e7d42;
  localparam logic [63:0] ID_TAB = {8'h02, 8'h00, ORG, PART};
  logic        ref_clk = 1'b0;
  logic        arst_n  = 1'b0;
  logic [2:0]  strap   = 3'h6;
  logic        cyc, stb, we, ack, hardRst, selfSup, busDrawn, rsv;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datW, datR;
  logic [2:0]  pwr;
  logic [7:0]  rd;
  int          n_fail = 0, n_compared = 0, nPulse = 0;
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (hardRst === 1'b1) nPulse <= nPulse + 1;
  pidpc_regs #(.ORG_ID(ORG), .PART_ID(PART)) dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
    .power_class_strap_pins(strap), .selfIdPower(pwr), .powerSelfSupplied(selfSup),
    .powerBusDrawn(busDrawn), .powerClassReserved(rsv), .phyHardReset(hardRst));
  pidpc_link_model lnk (.ref_clk(ref_clk), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(datW), .wb_dat_i(datR), .wb_ack_i(ack));
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    lnk.xfer(1'b1, 4'hf, idx, d, rd);
  endtask
  task automatic rdc(input logic [3:0] idx, input logic [7:0] exp);
    lnk.xfer(1'b0, 4'hf, idx, 8'h00, rd);
    check($sformatf("reg%0h", idx), exp, rd);
  endtask
  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    end_of_test();
  end
  initial begin
    // Reset is far shorter than in a system; the 2 ms floor would only lengthen the run.
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    rdc(4'h4, 8'h06);
    check("selfIdPower", 8'h06, {5'h0, pwr});
    for (int c = 0; c < 8; c++) begin
      wr(4'h4, 8'(c));
      rdc(4'h4, 8'(c));
      check("flags", {5'h0, c > 0 && c < 4, c == 4 || c > 5, c == 5}, {5'h0, selfSup, busDrawn, rsv});
    end
    lnk.xfer(1'b1, 4'he, 4'h4, 8'h01, rd);
    rdc(4'h4, 8'h07);
    rdc(4'h0, 8'h00);
    rdc(4'h8, 8'h00);
    wr(4'h7, 8'h20);
    rdc(4'h7, 8'h20);
    wr(4'ha, 8'hff);
    for (int i = 8; i < 16; i++) rdc(4'(i), ID_TAB[127 - 8 * i -: 8]);
    wr(4'h7, 8'he0);
    wr(4'he, 8'h7f);
    for (int i = 8; i < 16; i++) rdc(4'(i), 8'h00);
    strap <= 3'h3;
    wr(4'he, 8'h80);
    rdc(4'h7, 8'h00);
    rdc(4'h4, 8'h03);
    check("pulses", 8'h01, 8'(nPulse));
    check("selfIdPower", 8'h03, {5'h0, pwr});
    strap <= 3'h1;
    arst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    rdc(4'h4, 8'h01);
    rdc(4'h7, 8'h00);
    end_of_test();
  end
endmodule // pidpc_regs_tb
`default_nettype wire
